//--- design/dtlp_params.sv
// Operation
// R1: Logic output is AND, OR, XOR by code
// R2: Separate source selects for inputs A, B
// R3: Code 00: clear on ON edge, stop drive
// R4: Code 01: clear on OFF edge, stop drive
// R5: Code 02: ON edge clears, ignored while running
// R6: Terminal 11 ON/OFF delays, 0.1 s steps
// R7: Terminal 12 ON/OFF delays, 0.1 s steps
// R8: Relay ON/OFF delays, 0.1 s steps
// R9: Retention mode: default or keep last setpoint
// R10: Debug display flag is read only
// R11: Scale voltage command by span factor
// R12: Scale current-loop command by own span
// R13: Monitor output offset 0 to 100
// R14: Motor capacity code 0 to 12, per motor
// R15: Pole count 2, 4, 6 or 8 per motor
// R16: Stabilization constant 0 to 255 per motor
// R17: Delays tick at 0.1 s, edges restart
// R18: One register each, out-of-range writes rejected
module dtlp_params #(
  parameter int TICK_LEN = dtlp_pkg::TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire dtlp_pkg::dtlp_req_type req_i,
  output dtlp_pkg::dtlp_rsp_type rsp_o,
  input wire logic [dtlp_pkg::NSRC-1:0] logic_src_i,
  output logic logic_out_o,
  input wire logic out11_raw_i,
  input wire logic out12_raw_i,
  input wire logic relay_raw_i,
  output logic out11_o,
  output logic out12_o,
  output logic relay_o,
  input wire logic reset_pin_i,
  input wire logic running_i,
  output logic trip_clear_o,
  output logic drive_stop_o,
  output logic setpoint_keep_o,
  input wire logic debug_enable_i,
  input wire logic [15:0] volt_cmd_i,
  input wire logic [15:0] curr_cmd_i,
  output logic [15:0] volt_cmd_o,
  output logic [15:0] curr_cmd_o,
  output dtlp_pkg::dtlp_cfg_type cfg_o
);
  import dtlp_pkg::*;

  logic [15:0] regs_r [NREG];
  logic [4:0] wr_ix;
  logic wr_ok;
  dtlp_rsp_type rsp_r;

  function automatic logic [4:0] index_of(input logic [15:0] a);
    case (a)
      OFS_VOLT_SPAN: index_of = IX_VOLT_SPAN;
      OFS_CURR_SPAN: index_of = IX_CURR_SPAN;
      OFS_THERM_TUNE: index_of = IX_THERM_TUNE;
      OFS_MON_OFFSET: index_of = IX_MON_OFFSET;
      OFS_DEBUG_FLAG: index_of = IX_DEBUG_FLAG;
      OFS_RETAIN_MODE: index_of = IX_RETAIN_MODE;
      OFS_RESET_MODE: index_of = IX_RESET_MODE;
      OFS_LOGIC_A_SRC: index_of = IX_LOGIC_A_SRC;
      OFS_LOGIC_B_SRC: index_of = IX_LOGIC_B_SRC;
      OFS_LOGIC_OP: index_of = IX_LOGIC_OP;
      OFS_OUT11_ON: index_of = IX_OUT11_ON;
      OFS_OUT11_OFF: index_of = IX_OUT11_OFF;
      OFS_OUT12_ON: index_of = IX_OUT12_ON;
      OFS_OUT12_OFF: index_of = IX_OUT12_OFF;
      OFS_RELAY_ON: index_of = IX_RELAY_ON;
      OFS_RELAY_OFF: index_of = IX_RELAY_OFF;
      OFS_M1_CAP: index_of = IX_M1_CAP;
      OFS_M1_POLES: index_of = IX_M1_POLES;
      OFS_M1_STAB: index_of = IX_M1_STAB;
      OFS_M2_CAP: index_of = IX_M2_CAP;
      OFS_M2_POLES: index_of = IX_M2_POLES;
      OFS_M2_STAB: index_of = IX_M2_STAB;
      default: index_of = IX_NONE;
    endcase
  endfunction

  // Accepts a value only inside the documented range of the register
  function automatic logic in_range(input logic [4:0] ix, input logic [15:0] d);
    case (ix)
      IX_VOLT_SPAN, IX_CURR_SPAN, IX_THERM_TUNE: in_range = d <= MAX_SPAN;
      IX_MON_OFFSET: in_range = d <= MAX_MON_OFFSET;
      IX_RETAIN_MODE: in_range = d <= MAX_FLAG;
      IX_RESET_MODE, IX_LOGIC_OP: in_range = d <= MAX_MODE3;
      IX_LOGIC_A_SRC, IX_LOGIC_B_SRC: in_range = d <= MAX_SOURCE;
      IX_OUT11_ON, IX_OUT11_OFF, IX_OUT12_ON, IX_OUT12_OFF, IX_RELAY_ON,
      IX_RELAY_OFF: in_range = d <= MAX_DELAY;
      IX_M1_CAP, IX_M2_CAP: in_range = d <= MAX_CAP;
      IX_M1_POLES, IX_M2_POLES: in_range = d == 16'h0002 || d == 16'h0004 ||
                                          d == 16'h0006 || d == 16'h0008;
      IX_M1_STAB, IX_M2_STAB: in_range = d <= MAX_STAB;
      default: in_range = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] reset_value(input int ix);
    if (ix == int'(IX_VOLT_SPAN) || ix == int'(IX_CURR_SPAN) || ix == int'(IX_THERM_TUNE)) begin
      reset_value = RST_SPAN;
    end else if (ix == int'(IX_M1_POLES) || ix == int'(IX_M2_POLES)) begin
      reset_value = RST_POLES;
    end else begin
      reset_value = RST_ZERO;
    end
  endfunction

  // Command times span / 1000, saturated to 16 bits
  function automatic logic [15:0] scale(input logic [15:0] cmd, input logic [15:0] span);
    logic [31:0] prod;
    prod = (32'(cmd) * 32'(span)) / 32'(SPAN_UNITY);
    scale = (prod > 32'h0000ffff) ? 16'hffff : prod[15:0];
  endfunction

  // Register port
  assign wr_ix = index_of(req_i.addr);
  assign wr_ok = in_range(wr_ix, req_i.wdata); // see R10 see R18

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= reset_value(i);
      end
    end else begin
      if (req_i.wr && wr_ok) begin
        regs_r[wr_ix] <= req_i.wdata; // see R18
      end
      regs_r[IX_DEBUG_FLAG] <= {15'h0000, debug_enable_i}; // see R10
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack <= req_i.wr || req_i.rd;
      rsp_r.err <= (req_i.wr && !wr_ok) || (req_i.rd && !req_i.wr && wr_ix == IX_NONE);
      if (req_i.rd && !req_i.wr && wr_ix != IX_NONE) begin
        rsp_r.rdata <= regs_r[wr_ix];
      end else begin
        rsp_r.rdata <= 16'h0000;
      end
    end
  end
  assign rsp_o = rsp_r;

  // Settings to the drive
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_o <= '0;
      volt_cmd_o <= 16'h0000;
      curr_cmd_o <= 16'h0000;
      setpoint_keep_o <= 1'b0;
    end else begin
      volt_cmd_o <= scale(volt_cmd_i, regs_r[IX_VOLT_SPAN]); // see R11
      curr_cmd_o <= scale(curr_cmd_i, regs_r[IX_CURR_SPAN]); // see R12
      setpoint_keep_o <= regs_r[IX_RETAIN_MODE][0]; // see R9
      cfg_o.therm_tune <= regs_r[IX_THERM_TUNE];
      cfg_o.mon_offset <= regs_r[IX_MON_OFFSET]; // see R13
      cfg_o.m1_cap <= regs_r[IX_M1_CAP]; // see R14
      cfg_o.m2_cap <= regs_r[IX_M2_CAP]; // see R14
      cfg_o.m1_poles <= regs_r[IX_M1_POLES]; // see R15
      cfg_o.m2_poles <= regs_r[IX_M2_POLES]; // see R15
      cfg_o.m1_stab <= regs_r[IX_M1_STAB]; // see R16
      cfg_o.m2_stab <= regs_r[IX_M2_STAB]; // see R16
    end
  end

  // Logic output
  logic sel_a;
  logic sel_b;
  assign sel_a = logic_src_i[regs_r[IX_LOGIC_A_SRC][3:0]]; // see R2
  assign sel_b = logic_src_i[regs_r[IX_LOGIC_B_SRC][3:0]]; // see R2

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      logic_out_o <= 1'b0;
    end else begin
      case (regs_r[IX_LOGIC_OP][1:0])
        OP_AND: logic_out_o <= sel_a & sel_b; // see R1
        OP_OR: logic_out_o <= sel_a | sel_b; // see R1
        OP_XOR: logic_out_o <= sel_a ^ sel_b; // see R1
        default: logic_out_o <= 1'b0;
      endcase
    end
  end

  // Reset input: three-stage synchroniser, level accepted when stages 2 and 3 agree
  logic [2:0] rst_sync_r;
  logic rst_lvl_r;
  logic rst_rise;
  logic rst_fall;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rst_sync_r <= 3'h0;
      rst_lvl_r <= 1'b0;
    end else begin
      rst_sync_r <= {rst_sync_r[1:0], reset_pin_i};
      if (rst_sync_r[1] == rst_sync_r[2]) begin
        rst_lvl_r <= rst_sync_r[2];
      end
    end
  end
  assign rst_rise = (rst_sync_r[1] == rst_sync_r[2]) && rst_sync_r[2] && !rst_lvl_r;
  assign rst_fall = (rst_sync_r[1] == rst_sync_r[2]) && !rst_sync_r[2] && rst_lvl_r;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      trip_clear_o <= 1'b0;
      drive_stop_o <= 1'b0;
    end else begin
      trip_clear_o <= 1'b0;
      drive_stop_o <= 1'b0;
      case (regs_r[IX_RESET_MODE][1:0])
        RSP_ON_STOP: begin
          trip_clear_o <= rst_rise; // see R3
          drive_stop_o <= rst_rise && running_i; // see R3
        end
        RSP_OFF_STOP: begin
          trip_clear_o <= rst_fall; // see R4
          drive_stop_o <= rst_fall && running_i; // see R4
        end
        RSP_ON_IGNORE_RUN: begin
          trip_clear_o <= rst_rise && !running_i; // see R5
        end
        default: begin
          trip_clear_o <= 1'b0;
        end
      endcase
    end
  end

  // Tenth-second tick
  logic [31:0] tick_cnt_r;
  logic tick;
  assign tick = tick_cnt_r == 32'(TICK_LEN - 1);

  always_ff @(posedge mclk_i) begin
    if (srst_i || tick) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001; // see R17
    end
  end

  // ON/OFF delay channels: 0 terminal 11, 1 terminal 12, 2 relay
  logic [NCHAN-1:0] dly_in;
  logic [NCHAN-1:0] dly_prev_r;
  logic [NCHAN-1:0] dly_out_r;
  logic [15:0] dly_cnt_r [NCHAN];
  logic [15:0] dly_on [NCHAN];
  logic [15:0] dly_off [NCHAN];

  assign dly_in = {relay_raw_i, out12_raw_i, out11_raw_i};
  assign dly_on[0] = regs_r[IX_OUT11_ON]; // see R6
  assign dly_off[0] = regs_r[IX_OUT11_OFF]; // see R6
  assign dly_on[1] = regs_r[IX_OUT12_ON]; // see R7
  assign dly_off[1] = regs_r[IX_OUT12_OFF]; // see R7
  assign dly_on[2] = regs_r[IX_RELAY_ON]; // see R8
  assign dly_off[2] = regs_r[IX_RELAY_OFF]; // see R8

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dly_prev_r <= '0;
      dly_out_r <= '0;
      for (int c = 0; c < NCHAN; c++) begin
        dly_cnt_r[c] <= 16'h0000;
      end
    end else begin
      dly_prev_r <= dly_in;
      for (int c = 0; c < NCHAN; c++) begin
        if (dly_in[c] != dly_prev_r[c]) begin
          dly_cnt_r[c] <= 16'h0000; // see R17
        end else if (dly_in[c] != dly_out_r[c]) begin
          if (dly_cnt_r[c] >= (dly_in[c] ? dly_on[c] : dly_off[c])) begin
            dly_out_r[c] <= dly_in[c]; // see R6 see R7 see R8
            dly_cnt_r[c] <= 16'h0000;
          end else if (tick) begin
            dly_cnt_r[c] <= dly_cnt_r[c] + 16'h0001; // see R17
          end
        end else begin
          dly_cnt_r[c] <= 16'h0000;
        end
      end
    end
  end

  assign out11_o = dly_out_r[0];
  assign out12_o = dly_out_r[1];
  assign relay_o = dly_out_r[2];
endmodule

//--- design/dtlp_pkg.sv
package dtlp_pkg;
  localparam int NREG = 22;
  localparam logic [15:0] OFS_VOLT_SPAN = 16'h1141;
  localparam logic [15:0] OFS_CURR_SPAN = 16'h1142;
  localparam logic [15:0] OFS_THERM_TUNE = 16'h1144;
  localparam logic [15:0] OFS_MON_OFFSET = 16'h1145;
  localparam logic [15:0] OFS_DEBUG_FLAG = 16'h1148;
  localparam logic [15:0] OFS_RETAIN_MODE = 16'h1149;
  localparam logic [15:0] OFS_RESET_MODE = 16'h114a;
  localparam logic [15:0] OFS_LOGIC_A_SRC = 16'h1150;
  localparam logic [15:0] OFS_LOGIC_B_SRC = 16'h1151;
  localparam logic [15:0] OFS_LOGIC_OP = 16'h1152;
  localparam logic [15:0] OFS_OUT11_ON = 16'h1153;
  localparam logic [15:0] OFS_OUT11_OFF = 16'h1154;
  localparam logic [15:0] OFS_OUT12_ON = 16'h1155;
  localparam logic [15:0] OFS_OUT12_OFF = 16'h1156;
  localparam logic [15:0] OFS_RELAY_ON = 16'h1157;
  localparam logic [15:0] OFS_RELAY_OFF = 16'h1158;
  localparam logic [15:0] OFS_M1_CAP = 16'h1165;
  localparam logic [15:0] OFS_M1_POLES = 16'h1166;
  localparam logic [15:0] OFS_M1_STAB = 16'h1168;
  localparam logic [15:0] OFS_M2_CAP = 16'h1540;
  localparam logic [15:0] OFS_M2_POLES = 16'h1541;
  localparam logic [15:0] OFS_M2_STAB = 16'h1543;

  // Storage index of each register, in the order of the offsets above
  localparam logic [4:0] IX_VOLT_SPAN = 5'h00;
  localparam logic [4:0] IX_CURR_SPAN = 5'h01;
  localparam logic [4:0] IX_THERM_TUNE = 5'h02;
  localparam logic [4:0] IX_MON_OFFSET = 5'h03;
  localparam logic [4:0] IX_DEBUG_FLAG = 5'h04;
  localparam logic [4:0] IX_RETAIN_MODE = 5'h05;
  localparam logic [4:0] IX_RESET_MODE = 5'h06;
  localparam logic [4:0] IX_LOGIC_A_SRC = 5'h07;
  localparam logic [4:0] IX_LOGIC_B_SRC = 5'h08;
  localparam logic [4:0] IX_LOGIC_OP = 5'h09;
  localparam logic [4:0] IX_OUT11_ON = 5'h0a;
  localparam logic [4:0] IX_OUT11_OFF = 5'h0b;
  localparam logic [4:0] IX_OUT12_ON = 5'h0c;
  localparam logic [4:0] IX_OUT12_OFF = 5'h0d;
  localparam logic [4:0] IX_RELAY_ON = 5'h0e;
  localparam logic [4:0] IX_RELAY_OFF = 5'h0f;
  localparam logic [4:0] IX_M1_CAP = 5'h10;
  localparam logic [4:0] IX_M1_POLES = 5'h11;
  localparam logic [4:0] IX_M1_STAB = 5'h12;
  localparam logic [4:0] IX_M2_CAP = 5'h13;
  localparam logic [4:0] IX_M2_POLES = 5'h14;
  localparam logic [4:0] IX_M2_STAB = 5'h15;
  localparam logic [4:0] IX_NONE = 5'h1f;

  // Upper limits of each range
  localparam logic [15:0] MAX_SPAN = 16'h07d0;
  localparam logic [15:0] MAX_MON_OFFSET = 16'h0064;
  localparam logic [15:0] MAX_FLAG = 16'h0001;
  localparam logic [15:0] MAX_MODE3 = 16'h0002;
  localparam logic [15:0] MAX_SOURCE = 16'h0009;
  localparam logic [15:0] MAX_DELAY = 16'h03e8;
  localparam logic [15:0] MAX_CAP = 16'h000c;
  localparam logic [15:0] MAX_STAB = 16'h00ff;

  // Reset values
  localparam logic [15:0] RST_SPAN = 16'h03e8;
  localparam logic [15:0] RST_POLES = 16'h0004;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // Span factor full scale, 100.0 percent
  localparam logic [15:0] SPAN_UNITY = 16'h03e8;

  // Logic operator codes
  localparam logic [1:0] OP_AND = 2'h0;
  localparam logic [1:0] OP_OR = 2'h1;
  localparam logic [1:0] OP_XOR = 2'h2;

  // Reset input response codes
  localparam logic [1:0] RSP_ON_STOP = 2'h0;
  localparam logic [1:0] RSP_OFF_STOP = 2'h1;
  localparam logic [1:0] RSP_ON_IGNORE_RUN = 2'h2;

  // Delay tick timing
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam int NCHAN = 3;
  localparam int NSRC = 10;

  typedef struct packed {
    logic [15:0] therm_tune;
    logic [15:0] mon_offset;
    logic [15:0] m1_cap;
    logic [15:0] m1_poles;
    logic [15:0] m1_stab;
    logic [15:0] m2_cap;
    logic [15:0] m2_poles;
    logic [15:0] m2_stab;
  } dtlp_cfg_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dtlp_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } dtlp_rsp_type;
endpackage

//--- tb/dtlp_params_checker.sv
module dtlp_params_checker #(
  parameter int TICK_LEN = 10
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire dtlp_pkg::dtlp_req_type req_i,
  input wire dtlp_pkg::dtlp_rsp_type rsp_o,
  input wire logic trip_clear_o,
  input wire logic drive_stop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dtlp_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic any_req;
  logic bad_pole;
  assign any_req = req_i.wr | req_i.rd;
  assign bad_pole = !(req_i.wdata inside {16'h0002, 16'h0004, 16'h0006, 16'h0008});
  AST_ACK_TRACKS_REQ: assert property (rsp_o.ack == $past(any_req))
    else $error("ack does not follow request by one cycle");
  AST_ERR_NEEDS_ACK: assert property (rsp_o.err |-> rsp_o.ack)
    else $error("err without ack");
  AST_RDATA_IDLE_ZERO: assert property (!rsp_o.ack |-> rsp_o.rdata == 16'h0000)
    else $error("read data not zero outside ack");
  AST_RO_FLAG_WRITE: assert property (
    req_i.wr && req_i.addr == 16'h1148 |=> rsp_o.ack && rsp_o.err)
    else $error("write to read-only flag accepted");
  AST_SPAN_LIMIT: assert property (
    req_i.wr && req_i.addr inside {16'h1141, 16'h1142} && req_i.wdata > 16'h07d0 |=> rsp_o.err)
    else $error("span above limit accepted");
  AST_DELAY_LIMIT: assert property (
    req_i.wr && req_i.addr inside {[16'h1153:16'h1158]} && req_i.wdata > 16'h03e8
    |=> rsp_o.err)
    else $error("delay above limit accepted");
  AST_POLE_SET: assert property (
    req_i.wr && req_i.addr inside {16'h1166, 16'h1541} && bad_pole |=> rsp_o.err)
    else $error("illegal pole count accepted");
  AST_CAP_LIMIT: assert property (
    req_i.wr && req_i.addr inside {16'h1165, 16'h1540} && req_i.wdata > 16'h000c |=> rsp_o.err)
    else $error("capacity code above limit accepted");
  AST_CLEAR_PULSE: assert property (trip_clear_o |=> !trip_clear_o)
    else $error("trip clear longer than one cycle");
  AST_STOP_WITH_CLEAR: assert property (drive_stop_o |-> trip_clear_o)
    else $error("drive stop without trip clear");
endmodule

bind dtlp_params dtlp_params_checker #(.TICK_LEN(TICK_LEN)) u_chk (.mclk_i(mclk_i),
  .srst_i(srst_i), .req_i(req_i), .rsp_o(rsp_o), .trip_clear_o(trip_clear_o),
  .drive_stop_o(drive_stop_o));

//--- tb/dtlp_master.sv
module dtlp_master (
  input wire logic mclk_i,
  output dtlp_pkg::dtlp_req_type req_o,
  input wire dtlp_pkg::dtlp_rsp_type rsp_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import dtlp_pkg::*;
  initial req_o = '0;
  // One register access: request stands for the taking edge only
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ak, output logic e);
    @(posedge mclk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk_i);
    req_o <= '0;
    @(posedge mclk_i);
    ak = rsp_i.ack;
    e = rsp_i.err;
    q = rsp_i.rdata;
  endtask
endmodule

//--- tb/dtlp_params_tb.sv
module dtlp_params_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dtlp_pkg::*;
  localparam int TL = 10;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  dtlp_req_type req;
  dtlp_rsp_type rsp;
  dtlp_cfg_type cfg;
  logic [NSRC-1:0] src = '0;
  logic [2:0] raw = '0;
  logic [2:0] dout;
  logic pin = 1'b0;
  logic run = 1'b0;
  logic dbg = 1'b0;
  logic lout, clr, stop, keep;
  logic [15:0] vin = '0;
  logic [15:0] cin = '0;
  logic [15:0] vout, cout;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] ra [19] = '{16'h1141, 16'h1142, 16'h1144, 16'h1145, 16'h1149, 16'h114a,
    16'h1150, 16'h1151, 16'h1152, 16'h1153, 16'h1154, 16'h1155, 16'h1156, 16'h1157,
    16'h1158, 16'h1165, 16'h1168, 16'h1540, 16'h1543};
  logic [15:0] rm [19] = '{16'h7d0, 16'h7d0, 16'h7d0, 16'h64, 16'h1, 16'h2, 16'h9, 16'h9,
    16'h2, 16'h3e8, 16'h3e8, 16'h3e8, 16'h3e8, 16'h3e8, 16'h3e8, 16'hc, 16'hff, 16'hc, 16'hff};
  // Reset mode, running, pin level, expected clear, expected stop
  logic [5:0] pc [9] = '{6'h0f, 6'h08, 6'h14, 6'h12, 6'h1c, 6'h1b, 6'h2c, 6'h28, 6'h26};

  always #20 mclk_i = ~mclk_i;

  dtlp_master m (.mclk_i(mclk_i), .req_o(req), .rsp_i(rsp));

  dtlp_params #(.TICK_LEN(TL)) dut (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req),
    .rsp_o(rsp), .logic_src_i(src), .logic_out_o(lout), .out11_raw_i(raw[0]),
    .out12_raw_i(raw[1]), .relay_raw_i(raw[2]), .out11_o(dout[0]), .out12_o(dout[1]),
    .relay_o(dout[2]), .reset_pin_i(pin), .running_i(run), .trip_clear_o(clr),
    .drive_stop_o(stop), .setpoint_keep_o(keep), .debug_enable_i(dbg), .volt_cmd_i(vin),
    .curr_cmd_i(cin), .volt_cmd_o(vout), .curr_cmd_o(cout), .cfg_o(cfg));

  task automatic tally_and_finish();
    $display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e_exp);
    logic [15:0] q;
    logic ak, e;
    m.xfer(1'b1, a, d, q, ak, e);
    chk({ak, e}, {1'b1, e_exp});
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] d_exp, input logic e_exp);
    logic [15:0] q;
    logic ak, e;
    m.xfer(1'b0, a, 16'h0, q, ak, e);
    chk({ak, e, q}, {1'b1, e_exp, d_exp});
  endtask

  task automatic t_reset_values();
    rd(16'h1141, 16'h03e8, 1'b0);
    rd(16'h1541, 16'h0004, 1'b0);
    rd(16'h1158, 16'h0000, 1'b0);
    rd(16'h1143, 16'h0000, 1'b1);
    wr(16'h1143, 16'h0001, 1'b1);
  endtask

  task automatic t_ranges();
    for (int i = 0; i < 19; i++) begin
      wr(ra[i], rm[i], 1'b0);
      wr(ra[i], rm[i] + 16'h1, 1'b1);
      rd(ra[i], rm[i], 1'b0);
    end
    wr(16'h1166, 16'h0008, 1'b0);
    wr(16'h1166, 16'h0005, 1'b1);
    wr(16'h1541, 16'h0006, 1'b0);
    wr(16'h1541, 16'h0000, 1'b1);
    wr(16'h1148, 16'h0001, 1'b1);
    @(posedge mclk_i);
    dbg <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(16'h1148, 16'h0001, 1'b0);
    chk({cfg.m1_poles, cfg.m2_poles}, {16'h8, 16'h6});
    chk({cfg.mon_offset, cfg.m2_stab}, {16'h64, 16'hff});
    chk({cfg.m1_cap, cfg.m2_cap}, {16'hc, 16'hc});
    chk({cfg.therm_tune, cfg.m1_stab}, {16'h7d0, 16'hff});
    chk(keep, 1'b1);
    wr(16'h1149, 16'h0000, 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(keep, 1'b0);
  endtask

  task automatic t_logic();
    logic e;
    wr(16'h1150, 16'h0003, 1'b0);
    wr(16'h1151, 16'h0007, 1'b0);
    for (int op = 0; op < 3; op++) begin
      wr(16'h1152, 16'(op), 1'b0);
      for (int ab = 0; ab < 4; ab++) begin
        @(posedge mclk_i);
        src <= {2'b11, ab[0], 3'b101, ab[1], 3'b011};
        repeat (3) @(posedge mclk_i);
        e = op == 0 ? ab[1] & ab[0] : op == 1 ? ab[1] | ab[0] : ab[1] ^ ab[0];
        chk(lout, e);
      end
    end
  endtask

  task automatic t_pin();
    logic c, s;
    for (int i = 0; i < 9; i++) begin
      wr(16'h114a, {14'h0, pc[i][5:4]}, 1'b0);
      @(posedge mclk_i);
      run <= pc[i][3];
      pin <= pc[i][2];
      c = 1'b0;
      s = 1'b0;
      repeat (10) begin
        @(posedge mclk_i);
        c |= clr;
        s |= stop;
      end
      chk({c, s}, pc[i][1:0]);
    end
  endtask

  task automatic t_delay();
    int t [3];
    logic seen;
    for (int ch = 0; ch < 3; ch++) begin
      wr(16'h1153 + 16'(2 * ch), 16'(ch + 2), 1'b0);
      wr(16'h1154 + 16'(2 * ch), 16'h0000, 1'b0);
      t[ch] = 0;
    end
    @(posedge mclk_i);
    raw <= 3'b111;
    for (int k = 1; k < 80; k++) begin
      @(posedge mclk_i);
      for (int ch = 0; ch < 3; ch++) begin
        if (dout[ch] === 1'b1 && t[ch] == 0) t[ch] = k;
      end
    end
    for (int ch = 0; ch < 3; ch++) begin
      chk(t[ch] >= (ch + 1) * TL + 1 && t[ch] <= (ch + 2) * TL + 3, 1'b1);
    end
    raw <= 3'b000;
    repeat (3) @(posedge mclk_i);
    chk(dout, 3'b000);
    raw <= 3'b111;
    repeat (5) @(posedge mclk_i);
    raw <= 3'b000;
    seen = 1'b0;
    repeat (60) begin
      @(posedge mclk_i);
      seen |= |dout;
    end
    chk(seen, 1'b0);
  endtask

  task automatic t_span();
    wr(16'h1141, 16'h01f4, 1'b0);
    wr(16'h1142, 16'h07d0, 1'b0);
    @(posedge mclk_i);
    vin <= 16'h1000;
    cin <= 16'h9000;
    repeat (4) @(posedge mclk_i);
    chk({vout, cout}, {16'h0800, 16'hffff});
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_reset_values();
    t_ranges();
    t_logic();
    t_pin();
    t_delay();
    t_span();
    tally_and_finish();
  end
endmodule
